//--- rtl/utx_pin_sync.sv
`timescale 1ns/100ps
module utx_pin_sync (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic sys_ce,
   input  wire logic pin_i,
   output logic      level
);
   utx_pkg::utx_sync_type q;
   utx_pkg::utx_sync_type d;

   // The level follows only once the second and third stages agree.
   always_comb begin
      d       = q;
      d.s1    = pin_i;
      d.s2    = q.s1;
      d.s3    = q.s2;
      if (q.s2 == q.s3) begin
         d.level = q.s3;
      end
   end

   always_ff @(posedge sys_clk) begin
      // The line idles high, so starting at one avoids a false low after reset.
      if (sys_rst) begin
         q <= '1;
      end else if (sys_ce) begin
         q <= d;
      end
   end

   assign level = q.level;
endmodule

//--- rtl/utx_pkg.sv
package utx_pkg;
   typedef enum logic [1:0] {UTX_SH_IDLE, UTX_SH_SHIFT, UTX_SH_STOP} utx_sh_state_type;

   typedef struct packed {
      utx_sh_state_type st;
      logic [10:0]      sr;
      logic [3:0]       cnt;
      logic             txd;
      logic             done;
   } utx_sh_type;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } utx_sync_type;

   typedef struct packed {
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
      logic        dp_valid;
      logic        dp_write;
      logic [7:0]  dp_addr;
      logic [7:0]  hold;
      logic        full;
      logic [4:0]  ctrl;
      logic        tx_complete_flag;
      logic [1:0]  mask;
      logic        irq;
      logic        irq_empty;
      logic        irq_txc;
      logic        pin_o;
      logic        pin_oe;
   } utx_top_type;
endpackage

//--- rtl/utx_regs.svh
`ifndef UTX_REGS_SVH
`define UTX_REGS_SVH
// Behaviour
// [RULE1] Writing holding register starts a transmission.
// [RULE2] Idle shift register loads a new character at once.
// [RULE3] Character waits until current stop bit leaves.
// [RULE4] Load into shift register sets empty flag.
// [RULE5] Frame: start bit zero, stop bit one.
// [RULE6] Nine-bit mode copies ninth bit to position 9.
// [RULE7] Start bit appears on next baud tick.
// [RULE8] Data goes out LSB first, ninth, stop.
// [RULE9] Empty flag stays set until next write.
// [RULE10] Stop held one bit, nothing pending: complete.
// [RULE11] Disabled transmitter leaves pin as GPIO.
// [RULE12] Enabled transmitter drives pin, ignores direction bit.
// [RULE13] Separate complete and empty interrupt requests.
// [RULE14] Holding register write clears empty flag.
// [RULE15] Reset sets the empty flag.
// [RULE16] Complete flag cleared by vector or one-write.
// [RULE17] Software sets ninth bit before writing character.
// [RULE18] Idle line high; timing only on baud ticks.

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define UTX_OFS_DATA   8'h00
`define UTX_OFS_CTRL   8'h04
`define UTX_OFS_STATUS 8'h08
`define UTX_OFS_MASK   8'h0c

// ----------------------------------------------------------------
// Field positions, reset values and frame lengths
// ----------------------------------------------------------------
`define UTX_CTRL_EN    0
`define UTX_CTRL_NINE  1
`define UTX_CTRL_NINTH 2
`define UTX_CTRL_DIR   3
`define UTX_CTRL_GPO   4
`define UTX_ST_EMPTY   0
`define UTX_ST_TXC     1
`define UTX_ST_PIN     2
`define UTX_ST_BUSY    3
`define UTX_CTRL_RST   5'h00
`define UTX_MASK_RST   2'h0
`define UTX_LEN8       4'ha
`define UTX_LEN9       4'hb
`endif

//--- rtl/utx_shift_if.sv
`timescale 1ns/100ps
interface utx_shift_if;
   logic        load;
   logic [10:0] frame;
   logic [3:0]  frame_len;
   logic        ready;
   logic        done;
   logic        txd;

   modport ctl (output load, output frame, output frame_len,
                input ready, input done, input txd);
   modport sh  (input load, input frame, input frame_len,
                output ready, output done, output txd);
endinterface

//--- rtl/utx_shifter.sv
`timescale 1ns/100ps
module utx_shifter (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic sys_ce,
   input  wire logic enable,
   input  wire logic baud_tick,
   utx_shift_if.sh   port
);
   utx_pkg::utx_sh_type q;
   utx_pkg::utx_sh_type d;

   always_comb begin
      d      = q;
      d.done = 1'b0;
      unique case (q.st)
         utx_pkg::UTX_SH_IDLE: begin
            if (port.load) begin
               d.sr  = port.frame;
               d.cnt = port.frame_len;
               d.st  = utx_pkg::UTX_SH_SHIFT;
            end
         end
         utx_pkg::UTX_SH_SHIFT: begin
            if (baud_tick) begin
               d.txd = q.sr[0];                       // [RULE7] [RULE8]
               d.sr  = {1'b1, q.sr[10:1]};
               d.cnt = q.cnt - 4'h1;
               if (q.cnt == 4'h1) begin
                  d.st = utx_pkg::UTX_SH_STOP;
               end
            end
         end
         utx_pkg::UTX_SH_STOP: begin
            // A pending character follows the stop bit with no idle gap.
            if (port.load) begin
               d.sr  = port.frame;                    // [RULE3]
               d.cnt = port.frame_len;
               d.st  = utx_pkg::UTX_SH_SHIFT;
            end else if (baud_tick) begin
               d.done = 1'b1;                         // [RULE10]
               d.st   = utx_pkg::UTX_SH_IDLE;
            end
         end
      endcase
      // Dropping the enable abandons a character part way through.
      if (!enable) begin
         d.st  = utx_pkg::UTX_SH_IDLE;
         d.txd = 1'b1;                                // [RULE18]
         d.cnt = 4'h0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         q <= '{st: utx_pkg::UTX_SH_IDLE, sr: 11'h7ff, cnt: 4'h0, txd: 1'b1, done: 1'b0};
      end else if (sys_ce) begin
         q <= d;
      end
   end

   assign port.ready = (q.st != utx_pkg::UTX_SH_SHIFT);
   assign port.done  = q.done;
   assign port.txd   = q.txd;
endmodule

//--- rtl/utx_top.sv
`timescale 1ns/100ps
`include "utx_regs.svh"
module utx_top (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        sys_ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        baud_tick,
   input  wire logic        txc_vector_ack,
   input  wire logic        txd_pin_i,
   output logic             txd_pin_o,
   output logic             txd_pin_oe,
   output logic             irq,
   output logic             irq_tx_complete,
   output logic             irq_holding_empty
);
   utx_pkg::utx_top_type q;
   utx_pkg::utx_top_type d;
   utx_shift_if          sh ();
   logic                 pin_level;
   logic                 wr_data;
   logic                 wr_ctrl;
   logic                 wr_stat;
   logic                 wr_mask;
   logic                 load;
   logic                 en;

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   utx_shifter u_shifter (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .sys_ce    (sys_ce),
      .enable    (en),
      .baud_tick (baud_tick),
      .port      (sh.sh)
   );

   // The pin is read back so that software sees it while it serves as GPIO.
   utx_pin_sync u_pin_sync (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .sys_ce  (sys_ce),
      .pin_i   (txd_pin_i),
      .level   (pin_level)
   );

   // ----------------------------------------------------------------
   // Register file and transmit control
   // ----------------------------------------------------------------
   function automatic logic [31:0] rd_word(input logic [7:0] a,
                                           input utx_pkg::utx_top_type s,
                                           input logic pin, input logic busy);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (a)
         `UTX_OFS_DATA:   w[7:0] = s.hold;
         `UTX_OFS_CTRL:   w[4:0] = s.ctrl;
         `UTX_OFS_STATUS: w[3:0] = {busy, pin, s.tx_complete_flag, ~s.full};
         `UTX_OFS_MASK:   w[1:0] = s.mask;
         default:         w      = 32'h0000_0000;
      endcase
      return w;
   endfunction

   assign en      = q.ctrl[`UTX_CTRL_EN];
   assign wr_data = q.dp_valid && q.dp_write && (q.dp_addr == `UTX_OFS_DATA);
   assign wr_ctrl = q.dp_valid && q.dp_write && (q.dp_addr == `UTX_OFS_CTRL);
   assign wr_stat = q.dp_valid && q.dp_write && (q.dp_addr == `UTX_OFS_STATUS);
   assign wr_mask = q.dp_valid && q.dp_write && (q.dp_addr == `UTX_OFS_MASK);
   // Loading happens as soon as the shift register can take a character.
   assign load    = en && q.full && sh.ready;                 // [RULE1] [RULE2] [RULE3]

   assign sh.load      = load;
   assign sh.frame_len = q.ctrl[`UTX_CTRL_NINE] ? `UTX_LEN9 : `UTX_LEN8;
   // The ninth bit is sampled at load time, so it must be set beforehand.
   assign sh.frame     = q.ctrl[`UTX_CTRL_NINE] ?
                         {1'b1, q.ctrl[`UTX_CTRL_NINTH], q.hold, 1'b0} :   // [RULE6] [RULE17]
                         {2'b11, q.hold, 1'b0};                            // [RULE5]

   always_comb begin
      d           = q;
      d.hreadyout = 1'b1;
      d.hresp     = 1'b0;
      d.dp_valid  = hsel && htrans[1] && hready;
      if (d.dp_valid) begin
         d.dp_write = hwrite;
         d.dp_addr  = haddr[7:0];
      end
      if (load) begin
         d.full = 1'b0;                                       // [RULE4] [RULE9]
      end
      // A write in the loading cycle wins, so the new character is kept.
      if (wr_data) begin
         d.hold = hwdata[7:0];
         d.full = 1'b1;                                       // [RULE14]
      end
      if (wr_ctrl) begin
         d.ctrl = hwdata[4:0];
      end
      if (wr_mask) begin
         d.mask = hwdata[1:0];
      end
      if ((wr_stat && hwdata[`UTX_ST_TXC]) || txc_vector_ack) begin
         d.tx_complete_flag = 1'b0;                                        // [RULE16]
      end
      if (sh.done && !q.full) begin
         d.tx_complete_flag = 1'b1;                                        // [RULE10]
      end
      d.irq_empty = !q.full && q.mask[`UTX_ST_EMPTY];         // [RULE13]
      d.irq_txc   = q.tx_complete_flag && q.mask[`UTX_ST_TXC];             // [RULE13]
      d.irq       = d.irq_empty || d.irq_txc;
      if (en) begin
         d.pin_o  = sh.txd;                                   // [RULE18]
         d.pin_oe = 1'b1;                                     // [RULE12]
      end else begin
         d.pin_o  = q.ctrl[`UTX_CTRL_GPO];                    // [RULE11]
         d.pin_oe = q.ctrl[`UTX_CTRL_DIR];
      end
      // Reads see the register after any write of the previous data phase.
      if (d.dp_valid && !hwrite) begin
         d.hrdata = rd_word(haddr[7:0], d, pin_level, !sh.ready || d.full);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         q           <= '0;
         q.hreadyout <= 1'b1;
         q.full      <= 1'b0;                                 // [RULE15]
         q.ctrl      <= `UTX_CTRL_RST;
         q.mask      <= `UTX_MASK_RST;
         q.pin_o     <= 1'b1;
      end else if (sys_ce) begin
         q <= d;
      end
   end

   assign hreadyout         = q.hreadyout;
   assign hresp             = q.hresp;
   assign hrdata            = q.hrdata;
   assign txd_pin_o         = q.pin_o;
   assign txd_pin_oe        = q.pin_oe;
   assign irq               = q.irq;
   assign irq_tx_complete   = q.irq_txc;
   assign irq_holding_empty = q.irq_empty;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_write_char;
      sys_ce && wr_data;
   endsequence

   sequence s_load_char;
      sys_ce && load && !wr_data;
   endsequence

   property p_write_fills;
      s_write_char |=> q.full ##0 (q.hold == $past(hwdata[7:0]));
   endproperty
   a_write_fills: assert property (p_write_fills)             // [RULE14]
      else $error("holding write did not clear the empty flag");

   property p_load_empties;
      s_load_char |=> !q.full ##0 (u_shifter.q.st == utx_pkg::UTX_SH_SHIFT);
   endproperty
   a_load_empties: assert property (p_load_empties)           // [RULE4]
      else $error("load did not set the empty flag");

   property p_immediate_load;
      sys_ce && en && q.full && u_shifter.q.st == utx_pkg::UTX_SH_IDLE |-> load;
   endproperty
   a_immediate_load: assert property (p_immediate_load)       // [RULE2]
      else $error("idle shifter did not take the waiting character");

   property p_wait_stop;
      sys_ce && q.full && u_shifter.q.st == utx_pkg::UTX_SH_SHIFT |=> q.full;
   endproperty
   a_wait_stop: assert property (p_wait_stop)                 // [RULE3]
      else $error("character left holding register during shifting");

   property p_frame8;
      load && !q.ctrl[`UTX_CTRL_NINE] |->
         sh.frame[0] == 1'b0 && sh.frame[9] == 1'b1 && sh.frame[8:1] == q.hold
         && sh.frame_len == 4'ha;
   endproperty
   a_frame8: assert property (p_frame8)                       // [RULE5]
      else $error("eight-bit frame malformed");

   property p_frame9;
      load && q.ctrl[`UTX_CTRL_NINE] |->
         sh.frame[9] == q.ctrl[`UTX_CTRL_NINTH] && sh.frame[10] && !sh.frame[0]
         && sh.frame_len == 4'hb;
   endproperty
   a_frame9: assert property (p_frame9)                       // [RULE6]
      else $error("ninth bit not placed at position 9");

   property p_start_bit;
      sys_ce && en && baud_tick && u_shifter.q.st == utx_pkg::UTX_SH_SHIFT
         && u_shifter.q.cnt == sh.frame_len |=> !sh.txd;
   endproperty
   a_start_bit: assert property (p_start_bit)                 // [RULE7]
      else $error("start bit missing after load");

   property p_lsb_first;
      sys_ce && en && baud_tick && u_shifter.q.st == utx_pkg::UTX_SH_SHIFT
         |=> sh.txd == $past(u_shifter.q.sr[0]);
   endproperty
   a_lsb_first: assert property (p_lsb_first)                 // [RULE8]
      else $error("bit order wrong on the line");

   property p_empty_holds;
      sys_ce && !q.full && !wr_data |=> !q.full;
   endproperty
   a_empty_holds: assert property (p_empty_holds)             // [RULE9]
      else $error("empty flag dropped without a write");

   property p_txc_set;
      sys_ce && sh.done && !q.full |=> q.tx_complete_flag;
   endproperty
   a_txc_set: assert property (p_txc_set)                     // [RULE10]
      else $error("complete flag not set after stop bit");

   property p_txc_clear;
      sys_ce && txc_vector_ack && !sh.done |=> !q.tx_complete_flag;
   endproperty
   a_txc_clear: assert property (p_txc_clear)                 // [RULE16]
      else $error("complete flag not cleared by vector");

   property p_gpio;
      sys_ce && !en |=> txd_pin_oe == $past(q.ctrl[`UTX_CTRL_DIR])
         && txd_pin_o == $past(q.ctrl[`UTX_CTRL_GPO]);
   endproperty
   a_gpio: assert property (p_gpio)                           // [RULE11]
      else $error("disabled transmitter disturbed the GPIO pin");

   property p_drive;
      sys_ce && en |=> txd_pin_oe ##0 txd_pin_o == $past(sh.txd);
   endproperty
   a_drive: assert property (p_drive)                         // [RULE12]
      else $error("enabled transmitter not driving the pin");

   property p_idle_mark;
      sys_ce && en && u_shifter.q.st == utx_pkg::UTX_SH_IDLE |=> txd_pin_o;
   endproperty
   a_idle_mark: assert property (p_idle_mark)                 // [RULE18]
      else $error("idle line not at mark");

   property p_irq_split;
      sys_ce && q.tx_complete_flag && q.mask[`UTX_ST_TXC] && q.full
         |=> irq_tx_complete && !irq_holding_empty && irq;
   endproperty
   a_irq_split: assert property (p_irq_split)                 // [RULE13]
      else $error("complete request not separate from empty request");

   property p_start;
      s_write_char ##1 (sys_ce && en)[*2] |-> !q.full || u_shifter.q.st != utx_pkg::UTX_SH_IDLE;
   endproperty
   a_start: assert property (p_start)                         // [RULE1]
      else $error("written character never started");

   property p_reset_empty;
      $past(sys_rst) |-> !q.full;
   endproperty
   a_reset_empty: assert property (p_reset_empty)             // [RULE15]
      else $error("empty flag not set after reset");
endmodule

//--- verification/uart_transmitter_bench.sv
`timescale 1ns/100ps
`include "utx_regs.svh"
module uart_transmitter_bench;
   localparam int BIT = 8;
   logic        sys_clk   = 1'h0;
   logic        sys_rst   = 1'h1;
   logic        hsel      = 1'h0;
   logic [31:0] haddr     = 32'h0;
   logic [1:0]  htrans    = 2'h0;
   logic        hwrite    = 1'h0;
   logic [31:0] hwdata    = 32'h0;
   logic        baud_tick = 1'h0;
   logic        ack       = 1'h0;
   logic        nine_mode = 1'h0;
   logic [2:0]  tick_cnt  = 3'h0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic        pin_o;
   logic        pin_oe;
   logic        irq;
   logic        irq_txc;
   logic        irq_emp;
   logic [8:0]  rx_char;
   logic        rx_stop;
   int          rx_count;
   int          n_got       = 0;
   int          n_fail      = 0;
   int          comparisons = 0;
   // The line has a pull-up, so a released pin reads high.
   wire         line = pin_oe ? pin_o : 1'h1;

   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      tick_cnt <= tick_cnt + 3'h1;
      baud_tick <= (tick_cnt == 3'h7);
   end

   utx_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sys_ce(1'h1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .baud_tick(baud_tick), .txc_vector_ack(ack), .txd_pin_i(line), .txd_pin_o(pin_o),
      .txd_pin_oe(pin_oe), .irq(irq), .irq_tx_complete(irq_txc),
      .irq_holding_empty(irq_emp));

   utx_peer #(.BIT(BIT)) peer (.sys_clk(sys_clk), .line(line), .nine(nine_mode),
      .rx_char(rx_char), .rx_stop(rx_stop), .rx_count(rx_count));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic stop_test;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic timeout(input string what);
      n_fail++;
      $display("MISMATCH %s expected done seen timeout", what);
      stop_test();
   endtask

   task automatic wait_hr;
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'h1 && n < 20);
      if (hreadyout !== 1'h1) timeout("hready");
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      wait_hr();
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= wd;
      wait_hr();
      rd = hrdata;
   endtask

   task automatic expect_char(input logic [8:0] c);
      int n;
      n = 0;
      while (rx_count <= n_got && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      if (rx_count <= n_got) timeout("char");
      n_got++;
      check("char", {23'h0, c}, {23'h0, rx_char});
      check("stop", 32'h1, {31'h0, rx_stop});
   endtask

   task automatic poll_txc;
      int n;
      n = 0;
      do begin
         ahb(1'h0, `UTX_OFS_STATUS, 32'h0);
         n++;
      end while (rd[1] !== 1'h1 && n < 100);
      if (rd[1] !== 1'h1) timeout("txc");
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      ahb(1'h0, `UTX_OFS_STATUS, 32'h0);
      check("status", 32'h5, rd);
      ahb(1'h0, `UTX_OFS_CTRL, 32'h0);
      check("ctrl", 32'h0, rd);
      ahb(1'h0, 8'h10, 32'h0);
      check("unmapped", 32'h0, rd);
      check("oe", 32'h0, {31'h0, pin_oe});
      $display("test reset done");
   endtask

   task automatic t_gpio;
      ahb(1'h1, `UTX_OFS_CTRL, 32'h18);
      ahb(1'h1, `UTX_OFS_DATA, 32'ha5);
      ahb(1'h0, `UTX_OFS_STATUS, 32'h0);
      check("empty", 32'h0, {31'h0, rd[0]});
      check("gpio", 32'h3, {30'h0, pin_oe, pin_o});
      ahb(1'h1, `UTX_OFS_CTRL, 32'h01);
      ahb(1'h0, `UTX_OFS_STATUS, 32'h0);
      check("oe", 32'h1, {31'h0, pin_oe});
      expect_char(9'h0a5);
      poll_txc();
      check("flags", 32'h3, {30'h0, rd[1:0]});
      check("idle", 32'h3, {30'h0, pin_oe, pin_o});
      $display("test gpio done");
   endtask

   task automatic t_b2b;
      int n;
      ahb(1'h1, `UTX_OFS_MASK, 32'h1);
      ahb(1'h1, `UTX_OFS_DATA, 32'h3c);
      n = 0;
      while (line !== 1'h0 && n < BIT + 3) begin
         @(posedge sys_clk);
         n++;
      end
      check("start", 32'h0, {31'h0, line});
      ahb(1'h1, `UTX_OFS_DATA, 32'hc3);
      ahb(1'h0, `UTX_OFS_STATUS, 32'h0);
      check("empty", 32'h0, {31'h0, rd[0]});
      check("irq", 32'h0, {31'h0, irq_emp});
      expect_char(9'h03c);
      ahb(1'h0, `UTX_OFS_STATUS, 32'h0);
      check("empty", 32'h1, {31'h0, rd[0]});
      check("irq", 32'h3, {30'h0, irq, irq_emp});
      expect_char(9'h0c3);
      ahb(1'h1, `UTX_OFS_MASK, 32'h0);
      ahb(1'h0, `UTX_OFS_MASK, 32'h0);
      check("irq", 32'h0, {30'h0, irq, irq_emp});
      $display("test back to back done");
   endtask

   task automatic t_nine;
      nine_mode <= 1'h1;
      ahb(1'h1, `UTX_OFS_CTRL, 32'h07);
      ahb(1'h1, `UTX_OFS_DATA, 32'h55);
      expect_char(9'h155);
      ahb(1'h1, `UTX_OFS_CTRL, 32'h03);
      ahb(1'h1, `UTX_OFS_DATA, 32'h80);
      expect_char(9'h080);
      $display("test nine bit done");
   endtask

   task automatic t_complete;
      ahb(1'h1, `UTX_OFS_MASK, 32'h2);
      poll_txc();
      nine_mode <= 1'h0;
      check("irq", 32'h3, {30'h0, irq, irq_txc});
      ahb(1'h1, `UTX_OFS_STATUS, 32'h2);
      ahb(1'h0, `UTX_OFS_STATUS, 32'h0);
      check("txc", 32'h0, {31'h0, rd[1]});
      check("irq", 32'h0, {30'h0, irq, irq_txc});
      ahb(1'h1, `UTX_OFS_CTRL, 32'h01);
      ahb(1'h1, `UTX_OFS_DATA, 32'h11);
      expect_char(9'h011);
      poll_txc();
      ack <= 1'h1;
      @(posedge sys_clk);
      ack <= 1'h0;
      ahb(1'h0, `UTX_OFS_STATUS, 32'h0);
      check("txc", 32'h0, {31'h0, rd[1]});
      $display("test complete done");
   endtask

   initial begin
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'h0;
      @(posedge sys_clk);
      t_reset();
      t_gpio();
      t_b2b();
      t_nine();
      t_complete();
      stop_test();
   end
endmodule

//--- verification/utx_peer.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Remote serial receiver
// ----------------------------------------------------------------
// Bits are sampled mid-bit on the falling clock edge, so a sample never
// races the rising edge on which the pin register of the sender changes.
module utx_peer #(
   parameter int BIT = 8
) (
   input  wire logic  sys_clk,
   input  wire logic  line,
   input  wire logic  nine,
   output logic [8:0] rx_char,
   output logic       rx_stop,
   output int         rx_count
);
   initial begin
      rx_char = 9'h000;
      rx_stop = 1'h0;
      rx_count = 0;
      forever begin
         @(negedge line);
         repeat (BIT / 2) @(negedge sys_clk);
         if (line === 1'h0) begin
            rx_char = 9'h000;
            for (int i = 0; i < (nine ? 9 : 8); i++) begin
               repeat (BIT) @(negedge sys_clk);
               rx_char[i] = line;
            end
            repeat (BIT) @(negedge sys_clk);
            rx_stop = line;
            rx_count++;
         end
      end
   end
endmodule
